// file: logic/cbrtc_pkg.sv
/*
  Shared constants of the calendar/binary real-time clock: register map,
  control field positions, reset values and timing figures.
  Assumes a 20 MHz system clock and a 32.768 kHz sub-clock pin.
*/
package cbrtc_pkg;
  // Timing: the prescaler input runs at 256 Hz
  localparam int MCLK_HZ = 20_000_000;
  localparam int SUB_HZ = 32_768;
  localparam int TICK_HZ = 256;
  localparam int SUB_DIV_DEF = SUB_HZ / TICK_HZ;
  localparam int MAIN_TICK_CYCLES = MCLK_HZ / TICK_HZ;
  // Main-clock divider counts two mclk cycles per unit, so it fits 16 bits
  localparam logic [15:0] FREQ_RESET = 16'(MAIN_TICK_CYCLES / 2 - 1);

  // Register byte offsets
  localparam logic [11:0] OFF_SUBSEC = 12'h000;
  localparam logic [11:0] OFF_SEC = 12'h004;
  localparam logic [11:0] OFF_MIN = 12'h008;
  localparam logic [11:0] OFF_HOUR = 12'h00C;
  localparam logic [11:0] OFF_WDAY = 12'h010;
  localparam logic [11:0] OFF_DATE = 12'h014;
  localparam logic [11:0] OFF_MON = 12'h018;
  localparam logic [11:0] OFF_YEAR = 12'h01C;
  localparam logic [11:0] OFF_SEC_AL = 12'h020;
  localparam logic [11:0] OFF_MIN_AL = 12'h024;
  localparam logic [11:0] OFF_HOUR_AL = 12'h028;
  localparam logic [11:0] OFF_WDAY_AL = 12'h02C;
  localparam logic [11:0] OFF_DATE_AL = 12'h030;
  localparam logic [11:0] OFF_MON_AL = 12'h034;
  localparam logic [11:0] OFF_YEAR_AL = 12'h038;
  localparam logic [11:0] OFF_ALM_EN = 12'h03C;
  localparam logic [7:0] GRP_BIN_CNT = 8'h04;
  localparam logic [7:0] GRP_BIN_ALM = 8'h05;
  localparam logic [7:0] GRP_BIN_MASK = 8'h06;
  localparam logic [11:0] OFF_CTL1 = 12'h070;
  localparam logic [11:0] OFF_CTL2 = 12'h074;
  localparam logic [11:0] OFF_SRC = 12'h078;
  localparam logic [11:0] OFF_FREQ = 12'h07C;
  localparam logic [11:0] OFF_TRIM = 12'h080;
  localparam logic [3:0] GRP_CAP = 4'h1;
  localparam logic [3:0] CAP_LAST_IDX = 4'h9;

  // Control register 1 fields
  localparam int C1_AIE = 0;
  localparam int C1_CIE = 1;
  localparam int C1_PIE = 2;
  localparam int C1_OUTSEL = 3;
  localparam int C1_PES_LSB = 4;
  // Control register 2 fields
  localparam int C2_START = 0;
  localparam int C2_HALF_MINUTE_ADJUST = 2;
  localparam int C2_OE = 3;
  localparam int C2_AUTO_TRIM_ENABLE = 4;
  localparam int C2_AUTO_TRIM_PERIOD = 5;
  localparam int C2_HOURS_FORM_SELECT = 6;
  localparam int C2_MODE = 7;
  // Capture control fields
  localparam int CAP_EN = 0;
  localparam int CAP_EDGE_LSB = 1;
  localparam int CAP_FLAG = 7;
  localparam int CAP_CHANNELS = 3;

  // Reset values
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam logic [7:0] CTL2_RESET = 8'h40;
  localparam logic [7:0] ONE_BCD = 8'h01;

  // Periodic period codes and trim modes
  localparam logic [3:0] PES_DIV256 = 4'h6;
  localparam logic [3:0] PES_2S = 4'hF;
  localparam logic [1:0] TRIM_ADD = 2'h1;
  localparam logic [1:0] TRIM_SUB = 2'h2;
endpackage : cbrtc_pkg

// file: logic/cbrtc_top.sv
/*
  Calendar/binary real-time clock with APB register access, time capture,
  clock output, periodic event and wake-up outputs.
  Assumes a single 20 MHz mclk, synchronous active-high srst, a zero-wait
  APB master, and asynchronous sub-clock and capture pins.
*/
`timescale 1ns/1ns
`default_nettype none
module cbrtc_top #(
  parameter int SUB_DIV = cbrtc_pkg::SUB_DIV_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subClockIn,
  input wire logic [2:0] captureIn,
  output logic clockOutPin,
  output logic alarmIrq,
  output logic periodicIrq,
  output logic carryIrq,
  output logic wakeupReq,
  output logic periodicEvent
);
  if (SUB_DIV < 2 || SUB_DIV > 65536) begin : g_bad_div
    $error("SUB_DIV out of range");
  end

  typedef struct packed {
    logic clkS1, clkS2, clkS3;
    logic [2:0] capS1, capS2, capS3;
    logic [16:0] divCnt;
    logic [7:0] presc;
    logic twoSec;
    logic secUpd;
    logic [6:0] sec, min, hour;
    logic [2:0] wday;
    logic [5:0] date;
    logic [4:0] mon;
    logic [7:0] year;
    logic [31:0] bcnt;
    logic [6:0] secA, minA, hourA;
    logic [2:0] wdayA;
    logic [5:0] dateA;
    logic [4:0] monA;
    logic [7:0] yearA;
    logic [6:0] almEn;
    logic [31:0] balm, bmask;
    logic [7:0] ctl1, ctl2;
    logic srcMain;
    logic [15:0] freq;
    logic [7:0] trim;
    logic [5:0] trimLeft;
    logic [2:0][7:0] capCtl;
    logic [2:0][39:0] capVal;
    logic [31:0] prdata;
    logic alarmIrq, periodicIrq, carryIrq, wakeup, periodicEvent, clkOut;
  } cbrtc_state_t;

  cbrtc_state_t s, next_s;
  logic wrEn, rdSetup, tick, carry, adj, perHit, alarmHit, binMode;
  logic srcEdge, minStep, hourStep, dayStep, monStep, calMatch, binMatch;
  logic [1:0] step;
  logic [16:0] divEnd;
  logic [17:0] divSum;
  logic [7:0] prescInc, perMask;
  logic [3:0] pes;
  logic [2:0] capHit;
  logic [31:0] rdVal;

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcdInc

  // Last date of a month in BCD, leap years included
  function automatic logic [5:0] lastDate(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 5'h02) lastDate = leap ? 6'h29 : 6'h28;
    else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) lastDate = 6'h30;
    else lastDate = 6'h31;
  endfunction : lastDate

  // Address decode shared by the read mux and the error answer
  function automatic logic addrMapped(input logic [11:0] a);
    if (a[1:0] != 2'h0) addrMapped = 1'b0;
    else if (a <= cbrtc_pkg::OFF_ALM_EN) addrMapped = 1'b1;
    else if (a[11:4] >= cbrtc_pkg::GRP_BIN_CNT && a[11:4] <= cbrtc_pkg::GRP_BIN_MASK)
      addrMapped = 1'b1;
    else if (a >= cbrtc_pkg::OFF_CTL1 && a <= cbrtc_pkg::OFF_TRIM) addrMapped = 1'b1;
    else if (a[11:8] == cbrtc_pkg::GRP_CAP)
      addrMapped = a[7:6] != 2'h3 && a[5:2] <= cbrtc_pkg::CAP_LAST_IDX;
    else addrMapped = 1'b0;
  endfunction : addrMapped

  // Zero-wait slave: writes land in the access phase, reads sample at setup
  assign wrEn = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrMapped(paddr);
  assign prdata = s.prdata;
  assign clockOutPin = s.clkOut;
  assign alarmIrq = s.alarmIrq;
  assign periodicIrq = s.periodicIrq;
  assign carryIrq = s.carryIrq;
  assign wakeupReq = s.wakeup;
  assign periodicEvent = s.periodicEvent;

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.alarmIrq = 1'b0;
    next_s.periodicIrq = 1'b0;
    next_s.carryIrq = 1'b0;
    next_s.wakeup = 1'b0;
    next_s.periodicEvent = 1'b0;
    next_s.secUpd = 1'b0;
    // Pins pass two flops; the third stage only serves edge detection
    next_s.clkS1 = subClockIn;
    next_s.clkS2 = s.clkS1;
    next_s.clkS3 = s.clkS2;
    next_s.capS1 = captureIn;
    next_s.capS2 = s.capS1;
    next_s.capS3 = s.capS2;
    binMode = s.ctl2[cbrtc_pkg::C2_MODE];
    srcEdge = s.srcMain ? 1'b1 : (s.clkS2 & ~s.clkS3);
    // Trim steals or inserts one source count per pending unit
    step = {1'b0, srcEdge};
    if (s.trimLeft != 6'h00 && srcEdge) begin
      if (s.trim[7:6] == cbrtc_pkg::TRIM_ADD) step = 2'h2;
      else if (s.trim[7:6] == cbrtc_pkg::TRIM_SUB) step = 2'h0;
      next_s.trimLeft = s.trimLeft - 6'h01;
    end
    divEnd = s.srcMain ? {s.freq, 1'b1} : 17'(SUB_DIV - 1);
    divSum = {1'b0, s.divCnt} + {16'h0000, step};
    tick = 1'b0;
    if (s.ctl2[cbrtc_pkg::C2_START] && step != 2'h0) begin
      if (divSum > {1'b0, divEnd}) begin
        next_s.divCnt = 17'(divSum - {1'b0, divEnd} - 18'h00001);
        tick = 1'b1;
      end else begin
        next_s.divCnt = divSum[16:0];
      end
    end
    prescInc = s.presc + 8'h01;
    carry = tick && (s.presc == 8'hFF);
    if (tick) next_s.presc = prescInc;
    if (carry) begin
      next_s.twoSec = ~s.twoSec;
      next_s.secUpd = 1'b1;
      if (binMode) next_s.bcnt = s.bcnt + 32'h00000001;
    end
    // Calendar ripple: seconds, minutes, hours, dates, months, years
    adj = wrEn && paddr == cbrtc_pkg::OFF_CTL2 && pwdata[cbrtc_pkg::C2_HALF_MINUTE_ADJUST] && !binMode;
    minStep = 1'b0;
    hourStep = 1'b0;
    dayStep = 1'b0;
    monStep = 1'b0;
    if (adj) begin
      next_s.sec = 7'h00;
      next_s.presc = 8'h00;
      minStep = s.sec >= 7'h30;
    end else if (carry && !binMode) begin
      if (s.sec == 7'h59) begin
        next_s.sec = 7'h00;
        minStep = 1'b1;
      end else begin
        next_s.sec = 7'(bcdInc({1'b0, s.sec}));
      end
    end
    if (minStep) begin
      hourStep = s.min == 7'h59;
      next_s.min = hourStep ? 7'h00 : 7'(bcdInc({1'b0, s.min}));
    end
    if (hourStep) begin
      if (s.ctl2[cbrtc_pkg::C2_HOURS_FORM_SELECT]) begin
        dayStep = s.hour == 7'h23;
        next_s.hour = dayStep ? 7'h00 : 7'(bcdInc({1'b0, s.hour}));
      end else if (s.hour[5:0] == 6'h11) begin
        next_s.hour = {~s.hour[6], 6'h12};
        dayStep = s.hour[6];
      end else if (s.hour[5:0] == 6'h12) begin
        next_s.hour = {s.hour[6], 6'h01};
      end else begin
        next_s.hour = {s.hour[6], 6'(bcdInc({2'h0, s.hour[5:0]}))};
      end
    end
    if (dayStep) begin
      next_s.wday = (s.wday == 3'h6) ? 3'h0 : s.wday + 3'h1;
      monStep = s.date == lastDate(s.mon, s.year);
      next_s.date = monStep ? 6'h01 : 6'(bcdInc({2'h0, s.date}));
    end
    if (monStep) begin
      next_s.mon = (s.mon == 5'h12) ? 5'h01 : 5'(bcdInc({3'h0, s.mon}));
      if (s.mon == 5'h12) next_s.year = (s.year == 8'h99) ? 8'h00 : bcdInc(s.year);
    end
    // Periodic hit: codes 6..14 pick 1/256 s .. 1 s, code 15 picks 2 s
    pes = s.ctl1[cbrtc_pkg::C1_PES_LSB +: 4];
    perMask = 8'((9'h001 << (pes - cbrtc_pkg::PES_DIV256)) - 9'h001);
    perHit = 1'b0;
    if (tick && pes == cbrtc_pkg::PES_2S) perHit = carry & s.twoSec;
    else if (tick && pes >= cbrtc_pkg::PES_DIV256) perHit = (prescInc & perMask) == 8'h00;
    next_s.periodicEvent = perHit;
    next_s.periodicIrq = perHit & s.ctl1[cbrtc_pkg::C1_PIE];
    // Alarm checks the counters one cycle after they moved
    calMatch = s.almEn != 7'h00 && (!s.almEn[0] || s.sec == s.secA)
      && (!s.almEn[1] || s.min == s.minA) && (!s.almEn[2] || s.hour == s.hourA)
      && (!s.almEn[3] || s.wday == s.wdayA) && (!s.almEn[4] || s.date == s.dateA)
      && (!s.almEn[5] || s.mon == s.monA) && (!s.almEn[6] || s.year == s.yearA);
    binMatch = ((s.bcnt ^ s.balm) & s.bmask) == 32'h00000000;
    alarmHit = s.secUpd && (binMode ? binMatch : calMatch);
    next_s.alarmIrq = alarmHit & s.ctl1[cbrtc_pkg::C1_AIE];
    next_s.wakeup = next_s.alarmIrq | next_s.periodicIrq;
    // A read racing the prescaler may return a stale subsecond value
    next_s.carryIrq = s.ctl1[cbrtc_pkg::C1_CIE]
      & (carry | (rdSetup && paddr == cbrtc_pkg::OFF_SUBSEC && tick));
    next_s.clkOut = s.ctl2[cbrtc_pkg::C2_OE]
      & (s.ctl1[cbrtc_pkg::C1_OUTSEL] ? s.presc[1] : s.presc[7]);
    // Automatic trim: every 10 s or every minute (16 s or 64 s in binary)
    if (s.secUpd && s.ctl2[cbrtc_pkg::C2_AUTO_TRIM_ENABLE]) begin
      if (s.ctl2[cbrtc_pkg::C2_AUTO_TRIM_PERIOD] ? (binMode ? s.bcnt[3:0] == 4'h0 : s.sec[3:0] == 4'h0)
                                       : (binMode ? s.bcnt[5:0] == 6'h00 : s.sec == 7'h00))
        next_s.trimLeft = s.trim[5:0];
    end
    // Capture channels; values hold until the next enabled edge
    for (int c = 0; c < cbrtc_pkg::CAP_CHANNELS; c++) begin
      capHit[c] = s.capCtl[c][cbrtc_pkg::CAP_EN]
        & ((s.capCtl[c][cbrtc_pkg::CAP_EDGE_LSB] & s.capS2[c] & ~s.capS3[c])
        | (s.capCtl[c][cbrtc_pkg::CAP_EDGE_LSB + 1] & ~s.capS2[c] & s.capS3[c]));
      if (capHit[c]) begin
        next_s.capVal[c] = binMode ? {8'h00, s.bcnt}
          : {3'h0, s.mon, 2'h0, s.date, 1'b0, s.hour, 1'b0, s.min, 1'b0, s.sec};
        next_s.capCtl[c][cbrtc_pkg::CAP_FLAG] = 1'b1;
      end
    end
    // Register writes; software values override the count of this cycle
    if (wrEn) begin
      if (paddr == cbrtc_pkg::OFF_SEC) next_s.sec = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_MIN) next_s.min = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_HOUR) next_s.hour = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_WDAY) next_s.wday = pwdata[2:0];
      else if (paddr == cbrtc_pkg::OFF_DATE) next_s.date = pwdata[5:0];
      else if (paddr == cbrtc_pkg::OFF_MON) next_s.mon = pwdata[4:0];
      else if (paddr == cbrtc_pkg::OFF_YEAR) next_s.year = pwdata[7:0];
      else if (paddr == cbrtc_pkg::OFF_SEC_AL) next_s.secA = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_MIN_AL) next_s.minA = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_HOUR_AL) next_s.hourA = pwdata[6:0];
      else if (paddr == cbrtc_pkg::OFF_WDAY_AL) next_s.wdayA = pwdata[2:0];
      else if (paddr == cbrtc_pkg::OFF_DATE_AL) next_s.dateA = pwdata[5:0];
      else if (paddr == cbrtc_pkg::OFF_MON_AL) next_s.monA = pwdata[4:0];
      else if (paddr == cbrtc_pkg::OFF_YEAR_AL) next_s.yearA = pwdata[7:0];
      else if (paddr == cbrtc_pkg::OFF_ALM_EN) next_s.almEn = pwdata[6:0];
      else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_CNT)
        next_s.bcnt[paddr[3:2]*8 +: 8] = pwdata[7:0];
      else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_ALM)
        next_s.balm[paddr[3:2]*8 +: 8] = pwdata[7:0];
      else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_MASK)
        next_s.bmask[paddr[3:2]*8 +: 8] = pwdata[7:0];
      else if (paddr == cbrtc_pkg::OFF_CTL1) next_s.ctl1 = pwdata[7:0];
      else if (paddr == cbrtc_pkg::OFF_CTL2)
        next_s.ctl2 = pwdata[7:0] & ~(8'h01 << cbrtc_pkg::C2_HALF_MINUTE_ADJUST);
      else if (paddr == cbrtc_pkg::OFF_SRC) next_s.srcMain = pwdata[0];
      else if (paddr == cbrtc_pkg::OFF_FREQ) next_s.freq = pwdata[15:0];
      else if (paddr == cbrtc_pkg::OFF_TRIM) begin
        next_s.trim = pwdata[7:0];
        if (!s.ctl2[cbrtc_pkg::C2_AUTO_TRIM_ENABLE]) next_s.trimLeft = pwdata[5:0];
      end else if (paddr[11:8] == cbrtc_pkg::GRP_CAP && paddr[7:6] != 2'h3
                   && paddr[5:2] == 4'h0) begin
        // Flag clears by writing zero, but a capture in this cycle wins
        next_s.capCtl[paddr[7:6]][2:0] = pwdata[2:0];
        next_s.capCtl[paddr[7:6]][cbrtc_pkg::CAP_FLAG] = capHit[paddr[7:6]]
          | (s.capCtl[paddr[7:6]][cbrtc_pkg::CAP_FLAG] & pwdata[cbrtc_pkg::CAP_FLAG]);
      end
    end
    // Read mux; capture reads never touch the running counters
    rdVal = 32'h00000000;
    if (paddr == cbrtc_pkg::OFF_SUBSEC) rdVal = {25'h0, s.presc[7:1]};
    else if (paddr == cbrtc_pkg::OFF_SEC) rdVal = {25'h0, s.sec};
    else if (paddr == cbrtc_pkg::OFF_MIN) rdVal = {25'h0, s.min};
    else if (paddr == cbrtc_pkg::OFF_HOUR) rdVal = {25'h0, s.hour};
    else if (paddr == cbrtc_pkg::OFF_WDAY) rdVal = {29'h0, s.wday};
    else if (paddr == cbrtc_pkg::OFF_DATE) rdVal = {26'h0, s.date};
    else if (paddr == cbrtc_pkg::OFF_MON) rdVal = {27'h0, s.mon};
    else if (paddr == cbrtc_pkg::OFF_YEAR) rdVal = {24'h0, s.year};
    else if (paddr == cbrtc_pkg::OFF_SEC_AL) rdVal = {25'h0, s.secA};
    else if (paddr == cbrtc_pkg::OFF_MIN_AL) rdVal = {25'h0, s.minA};
    else if (paddr == cbrtc_pkg::OFF_HOUR_AL) rdVal = {25'h0, s.hourA};
    else if (paddr == cbrtc_pkg::OFF_WDAY_AL) rdVal = {29'h0, s.wdayA};
    else if (paddr == cbrtc_pkg::OFF_DATE_AL) rdVal = {26'h0, s.dateA};
    else if (paddr == cbrtc_pkg::OFF_MON_AL) rdVal = {27'h0, s.monA};
    else if (paddr == cbrtc_pkg::OFF_YEAR_AL) rdVal = {24'h0, s.yearA};
    else if (paddr == cbrtc_pkg::OFF_ALM_EN) rdVal = {25'h0, s.almEn};
    else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_CNT) rdVal = {24'h0, s.bcnt[paddr[3:2]*8 +: 8]};
    else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_ALM) rdVal = {24'h0, s.balm[paddr[3:2]*8 +: 8]};
    else if (paddr[11:4] == cbrtc_pkg::GRP_BIN_MASK) rdVal = {24'h0, s.bmask[paddr[3:2]*8 +: 8]};
    else if (paddr == cbrtc_pkg::OFF_CTL1) rdVal = {24'h0, s.ctl1};
    else if (paddr == cbrtc_pkg::OFF_CTL2) rdVal = {24'h0, s.ctl2};
    else if (paddr == cbrtc_pkg::OFF_SRC) rdVal = {31'h0, s.srcMain};
    else if (paddr == cbrtc_pkg::OFF_FREQ) rdVal = {16'h0, s.freq};
    else if (paddr == cbrtc_pkg::OFF_TRIM) rdVal = {24'h0, s.trim};
    else if (addrMapped(paddr) && paddr[11:8] == cbrtc_pkg::GRP_CAP) begin
      if (paddr[5:2] == 4'h0) rdVal = {24'h0, s.capCtl[paddr[7:6]]};
      else if (paddr[5:2] <= 4'h5)
        rdVal = {24'h0, s.capVal[paddr[7:6]][(paddr[5:2] - 4'h1)*8 +: 8]};
      else rdVal = {24'h0, s.capVal[paddr[7:6]][(paddr[5:2] - 4'h6)*8 +: 8]};
    end
    if (rdSetup) next_s.prdata = rdVal;
  end

  // State register; defaults are 2000-01-01 00:00:00, stopped, 24-hour
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.date <= cbrtc_pkg::ONE_BCD[5:0];
      s.mon <= cbrtc_pkg::ONE_BCD[4:0];
      s.ctl1 <= cbrtc_pkg::CTL1_RESET;
      s.ctl2 <= cbrtc_pkg::CTL2_RESET;
      s.freq <= cbrtc_pkg::FREQ_RESET;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_alarm_gate: assert property (alarmIrq |-> $past(s.ctl1[cbrtc_pkg::C1_AIE]))
    else $error("alarm irq while disabled");
  a_period_gate: assert property (periodicIrq |-> periodicEvent)
    else $error("periodic irq without event");
  a_wake_follow: assert property ((alarmIrq || periodicIrq) |-> wakeupReq)
    else $error("wake-up missing");
  a_sec_wrap: assert property (carry && !binMode && s.sec == 7'h59 && !wrEn && !adj
    |=> s.sec == 7'h00 && s.min == $past(s.min == 7'h59 ? 7'h00 : 7'(bcdInc({1'b0, s.min}))))
    else $error("seconds wrap wrong");
  a_bin_step: assert property (carry && binMode && !wrEn |=> s.bcnt == $past(s.bcnt) + 32'h1)
    else $error("binary count did not step");
  a_adj_clear: assert property (adj |=> s.sec == 7'h00 && s.presc == 8'h00)
    else $error("half-minute adjust failed");
  a_clkout_off: assert property (!s.ctl2[cbrtc_pkg::C2_OE] |=> !clockOutPin)
    else $error("clock out while disabled");
  a_carry_irq: assert property (carry && s.ctl1[cbrtc_pkg::C1_CIE] |=> carryIrq)
    else $error("carry irq missing");
  a_cap_hold: assert property (!capHit[0] |=> $stable(s.capVal[0]))
    else $error("capture changed without edge");
  a_stop_hold: assert property (!s.ctl2[cbrtc_pkg::C2_START] && !wrEn |=> $stable(s.presc))
    else $error("prescaler moved while stopped");
  c_alarm: cover property (alarmIrq);
  c_periodic: cover property (periodicIrq);
  c_capture: cover property (capHit[0] ##1 s.capCtl[0][cbrtc_pkg::CAP_FLAG]);
  c_adjust_up: cover property (adj && s.sec >= 7'h30);
endmodule : cbrtc_top
`default_nettype wire

// file: testbench/cbrtc_tb.sv
/*
  Self-checking bench for the calendar/binary clock: register rows, half-minute
  adjust, leap day, binary alarm, periodic gating, clock out, capture, 12-hour, reset.
  Assumes the main clock as count source with divider 0, so one tick is 2 mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data;} cbrtc_row_t;
  logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, err, subClockIn = 1'b0, clockOutPin, alarmIrq, periodicIrq;
  logic [2:0] captureIn = 3'h0;
  logic carryIrq, wakeupReq, periodicEvent;
  int n_fail = 0, check_count = 0, i, n;
  cbrtc_row_t rows [16] = '{
    '{1'b0, cbrtc_pkg::OFF_CTL2, 32'h40}, '{1'b0, cbrtc_pkg::OFF_DATE, 32'h01},
    '{1'b0, cbrtc_pkg::OFF_MON, 32'h01}, '{1'b0, cbrtc_pkg::OFF_FREQ, 32'h9895},
    '{1'b0, cbrtc_pkg::OFF_CTL1, 32'h00}, '{1'b0, cbrtc_pkg::OFF_SEC, 32'h00},
    '{1'b1, cbrtc_pkg::OFF_MIN, 32'h15}, '{1'b1, cbrtc_pkg::OFF_SEC, 32'h45},
    '{1'b1, cbrtc_pkg::OFF_CTL2, 32'h44}, '{1'b0, cbrtc_pkg::OFF_SEC, 32'h00},
    '{1'b0, cbrtc_pkg::OFF_MIN, 32'h16}, '{1'b0, cbrtc_pkg::OFF_CTL2, 32'h40},
    '{1'b1, cbrtc_pkg::OFF_SEC, 32'h29}, '{1'b1, cbrtc_pkg::OFF_CTL2, 32'h44},
    '{1'b0, cbrtc_pkg::OFF_SEC, 32'h00}, '{1'b0, cbrtc_pkg::OFF_MIN, 32'h16}};
  cbrtc_top #(.SUB_DIV(2)) dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subClockIn(subClockIn), .captureIn(captureIn),
    .clockOutPin(clockOutPin), .alarmIrq(alarmIrq), .periodicIrq(periodicIrq),
    .carryIrq(carryIrq), .wakeupReq(wakeupReq), .periodicEvent(periodicEvent));
  // 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // Sub-clock pin keeps toggling even though the main clock is the source
  always @(posedge mclk) subClockIn <= ~subClockIn;
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // The polling loop stopped inside its bound and the pulse is really there
  task automatic settle(input int lim, input logic flag);
    chk(32'(n < lim && flag === 1'b1), 32'h1);
  endtask : settle
  // Count the cycles in which the clock output pin is high
  task automatic count_high(input int len);
    n = 0;
    repeat (len) begin
      @(posedge mclk);
      n += int'(clockOutPin);
    end
  endtask : count_high
  // Watchdog sized well above the planned few thousand cycles
  initial begin
    #(50 * 20000);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    foreach (rows[r]) begin
      apb(rows[r].wr, rows[r].addr, rows[r].data);
      if (!rows[r].wr) chk(q, rows[r].data);
    end
    $display("Test register rows done");
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    // Leap day: 23:59:59 on 28 Feb of year 24, running from the main clock
    apb(1'b1, cbrtc_pkg::OFF_SRC, 32'h1);
    apb(1'b1, cbrtc_pkg::OFF_FREQ, 32'h0);
    apb(1'b1, cbrtc_pkg::OFF_YEAR, 32'h24);
    apb(1'b1, cbrtc_pkg::OFF_MON, 32'h02);
    apb(1'b1, cbrtc_pkg::OFF_DATE, 32'h28);
    apb(1'b1, cbrtc_pkg::OFF_HOUR, 32'h23);
    apb(1'b1, cbrtc_pkg::OFF_MIN, 32'h59);
    apb(1'b1, cbrtc_pkg::OFF_SEC, 32'h59);
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'h02);
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h41);
    for (n = 0; n < 1200 && carryIrq !== 1'b1; n++) @(posedge mclk);
    settle(1200, carryIrq);
    rd(cbrtc_pkg::OFF_SEC, 32'h00);
    rd(cbrtc_pkg::OFF_HOUR, 32'h00);
    rd(cbrtc_pkg::OFF_DATE, 32'h29);
    rd(cbrtc_pkg::OFF_MON, 32'h02);
    $display("Test leap day done");
    // Binary mode: 0xFF rolls to 0x100, alarm on masked low half word
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h80);
    for (i = 0; i < 12; i++) begin
      apb(1'b1, 12'h040 + 12'(4 * i), (i == 0 || i == 8 || i == 9) ? 32'hFF :
        (i == 5) ? 32'h01 : 32'h00);
    end
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'h01);
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h81);
    for (n = 0; n < 1200 && alarmIrq !== 1'b1; n++) @(posedge mclk);
    settle(1200, alarmIrq);
    chk({31'h0, wakeupReq}, 32'h1);
    rd(12'h040, 32'h00);
    rd(12'h044, 32'h01);
    $display("Test binary alarm done");
    // Periodic half second is 128 ticks, 256 mclk cycles apart
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'hD4);
    for (n = 0; n < 600 && periodicIrq !== 1'b1; n++) @(posedge mclk);
    settle(600, periodicIrq);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (periodicIrq !== 1'b1 && n < 600);
    chk(32'(n), 32'd256);
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'hD0);
    for (n = 0; n < 600 && periodicEvent !== 1'b1; n++) @(posedge mclk);
    settle(600, periodicEvent);
    chk({31'h0, periodicIrq}, 32'h0);
    $display("Test periodic done");
    // 64 Hz out is 8 mclk per period here, half high; reads let the pin settle
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'h08);
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h89);
    rd(cbrtc_pkg::OFF_CTL1, 32'h08);
    count_high(16);
    chk(32'(n), 32'd8);
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h81);
    rd(cbrtc_pkg::OFF_CTL2, 32'h81);
    count_high(16);
    chk(32'(n), 32'd0);
    $display("Test clock out done");
    // Capture channel 0 on a rising edge, counter stopped at a known value
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h80);
    apb(1'b1, 12'h040, 32'h5A);
    apb(1'b1, 12'h100, 32'h03);
    captureIn <= 3'h1;
    repeat (6) @(posedge mclk);
    apb(1'b1, 12'h040, 32'h00);
    rd(12'h100, 32'h83);
    rd(12'h118, 32'h5A);
    rd(12'h140, 32'h00);
    $display("Test capture done");
    // 12-hour form: 11:59:59 in the morning rolls to 12 in the afternoon
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h00);
    apb(1'b1, cbrtc_pkg::OFF_HOUR, 32'h11);
    apb(1'b1, cbrtc_pkg::OFF_MIN, 32'h59);
    apb(1'b1, cbrtc_pkg::OFF_SEC, 32'h59);
    apb(1'b1, cbrtc_pkg::OFF_CTL1, 32'h02);
    apb(1'b1, cbrtc_pkg::OFF_CTL2, 32'h01);
    for (n = 0; n < 1200 && carryIrq !== 1'b1; n++) @(posedge mclk);
    settle(1200, carryIrq);
    rd(cbrtc_pkg::OFF_HOUR, 32'h52);
    $display("Test 12-hour done");
    // Second reset in mid-run clears the outputs and restores control 2
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({25'h0, clockOutPin, alarmIrq, periodicIrq, carryIrq, wakeupReq, periodicEvent,
      pslverr}, 32'h0);
    srst <= 1'b0;
    rd(cbrtc_pkg::OFF_CTL2, 32'h40);
    $display("Test second reset done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
